// [sbf_host_fifo.sv]
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sbf_host_fifo
   import sbf_pkg::*;
#(
   parameter int TX_DEPTH = 512,
   parameter int RX_DEPTH = 1024,
   localparam int TAW = $clog2(TX_DEPTH),
   localparam int RAW = $clog2(RX_DEPTH)
) (
   // Clock, enable and reset.
   input wire logic clk_sys,
   input wire logic ce,
   input wire logic nrst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Asynchronous transmitter drain.
   output logic async_tx_valid,
   output logic [32:0] async_tx_data,
   input wire logic async_tx_ready,
   input wire logic async_tx_mid,
   // Isochronous transmitter drain.
   output logic iso_tx_valid,
   output logic [32:0] iso_tx_data,
   input wire logic iso_tx_ready,
   input wire logic iso_tx_mid,
   // Receiver fill.
   input wire logic rx_start,
   input wire logic [1:0] rx_speed,
   input wire logic [3:0] rx_tcode,
   input wire logic rx_special,
   input wire logic rx_no_ack,
   input wire logic rx_single_block,
   input wire logic rx_q_valid,
   input wire logic [31:0] rx_q_data,
   output logic rx_ready,
   input wire logic rx_end,
   input wire logic [3:0] rx_ack,
   input wire logic [3:0] snooped_ack,
   // Event flags.
   output logic async_fifo_bad_irq,
   output logic iso_fifo_bad_irq,
   output logic rx_data_irq
);
   // ==================================================================
   // Bus decode.
   logic wr_en, rd_en, in_burst, rd_wait, snoop_enable, trigger_enable, flush_bad;
   logic [7:0] burst_addr;
   logic [8:0] trig_size;
   logic [2:0] evt;
   logic [1:0] tx_ready, tx_mid, tx_valid, bad, err_ev, refuse, clr;
   logic [32:0] tx_data [2];
   logic mapped, tx_loc, rx_pub_ev;
   logic [31:0] next_prdata;

   assign wr_en = ce && psel && penable && pwrite;
   assign rd_en = ce && psel && penable && !pwrite && rd_wait;
   assign tx_loc = paddr inside {TX_FIRST[0], TX_FIRST[1], TX_CONT[0], TX_CONT[1],
                                 TX_UPD[0], TX_UPD[1], TX_BURST[0], TX_BURST[1]};
   assign mapped = tx_loc || paddr inside {A_CTRL, A_TRIG, A_EVT, A_RXSTAT, A_RXREAD};
   assign pready = ce && (pwrite || rd_wait);
   assign pslverr = psel && penable && (!mapped || (pwrite && (paddr == A_RXREAD || paddr == A_RXSTAT))
                    || (!pwrite && tx_loc) || (|refuse));
   assign tx_ready = {iso_tx_ready, async_tx_ready};
   assign tx_mid = {iso_tx_mid, async_tx_mid};
   assign async_tx_valid = tx_valid[0];
   assign iso_tx_valid = tx_valid[1];
   assign async_tx_data = tx_data[0];
   assign iso_tx_data = tx_data[1];
   assign clr[0] = wr_en && paddr == A_CTRL && pwdata[CTRL_ACLR];
   assign clr[1] = wr_en && paddr == A_CTRL && pwdata[CTRL_ICLR];

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         in_burst <= 1'b0;
         burst_addr <= 8'h00;
      end else if (ce) begin
         if (!psel || (penable && !pwrite)) begin
            in_burst <= 1'b0;
         end else if (wr_en) begin
            in_burst <= 1'b1;
            burst_addr <= paddr;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rd_wait <= 1'b0;
      end else if (ce) begin
         rd_wait <= psel && penable && !pwrite && !rd_wait;
      end
   end

   // ==================================================================
   // Software registers.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         {flush_bad, trigger_enable, snoop_enable} <= CTRL_RST;
         trig_size <= TRIG_RST;
      end else if (ce && wr_en) begin
         if (paddr == A_CTRL) begin
            snoop_enable <= pwdata[CTRL_SNOOP];
            trigger_enable <= pwdata[CTRL_TRIGGER_ENABLE];
            flush_bad <= pwdata[CTRL_FBAD];
         end
         if (paddr == A_TRIG) begin
            trig_size <= pwdata[8:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         evt <= EVT_RST;
      end else if (ce) begin
         evt <= (evt & ~((wr_en && paddr == A_EVT) ? pwdata[2:0] : 3'h0)) | {rx_pub_ev, err_ev};
      end
   end

   assign async_fifo_bad_irq = evt[0];
   assign iso_fifo_bad_irq = evt[1];
   assign rx_data_irq = evt[2];

   // ==================================================================
   // Transmit FIFOs.
   for (genvar ch = 0; ch < 2; ch++) begin : g_tx
      logic h_first, h_cont, h_upd, h_burst, bend, we, wctl, pop, empty, hold, open, bad_q;
      logic [TAW:0] wptr, rptr, conf, cnt, next_cnt;

      assign h_first = wr_en && paddr == TX_FIRST[ch];
      assign h_cont = wr_en && paddr == TX_CONT[ch];
      assign h_upd = wr_en && paddr == TX_UPD[ch];
      assign h_burst = wr_en && paddr == TX_BURST[ch];
      assign bend = in_burst && burst_addr == TX_BURST[ch] && !(psel && pwrite && paddr == TX_BURST[ch]);
      assign bad[ch] = bad_q;
      assign cnt = wptr - rptr;
      assign empty = cnt == '0;
      assign refuse[ch] = (h_first || h_cont || h_upd || h_burst) && cnt == (TAW+1)'(TX_DEPTH);
      assign we = (h_first || h_cont || h_upd || h_burst) && !refuse[ch] && !clr[ch];
      assign wctl = h_first || (h_burst && !(in_burst && burst_addr == TX_BURST[ch]));
      assign tx_valid[ch] = conf != '0 && !bad[ch] && !hold;
      assign pop = ce && tx_valid[ch] && tx_ready[ch];
      assign err_ev[ch] = ce && (((h_cont || h_upd) && !open) || (tx_ready[ch] && tx_mid[ch] && empty));
      assign next_cnt = cnt + (TAW+1)'(we) - (TAW+1)'(pop);

      always_ff @(posedge clk_sys) begin
         if (!nrst) begin
            wptr <= '0;
            rptr <= '0;
            conf <= '0;
            bad_q <= 1'b0;
            open <= 1'b0;
            hold <= 1'b0;
         end else if (ce) begin
            hold <= pop || (we && empty);
            bad_q <= err_ev[ch] || (bad_q && !clr[ch]);
            if (clr[ch]) begin
               wptr <= '0;
               rptr <= '0;
               conf <= '0;
               open <= 1'b0;
            end else begin
               wptr <= wptr + (TAW+1)'(we);
               rptr <= rptr + (TAW+1)'(pop);
               if (h_first || h_burst) begin
                  open <= 1'b1;
               end
               if ((h_upd && we) || bend) begin
                  conf <= next_cnt;
               end else begin
                  conf <= conf - (TAW+1)'(pop);
               end
            end
         end
      end

      sbf_ram #(.W(33), .DEPTH(TX_DEPTH)) u_ram (
         .clk_sys(clk_sys),
         .ce(ce),
         .we(we),
         .waddr(wptr[TAW-1:0]),
         .wdata({wctl, pwdata}),
         .raddr(rptr[TAW-1:0]),
         .rdata(tx_data[ch])
      );

      a_first_ctl: assert property (@(posedge clk_sys) disable iff (!nrst)
         we && h_first |-> wctl && !bend)
         else $error("first location stored without control bit");
      a_burst_rest: assert property (@(posedge clk_sys) disable iff (!nrst)
         h_burst && in_burst && burst_addr == TX_BURST[ch] |-> !wctl)
         else $error("burst continuation stored with control bit");
      a_cont_unconf: assert property (@(posedge clk_sys) disable iff (!nrst)
         ce && (h_cont || h_first) && !bend && !clr[ch] |=> conf == $past(conf) - (TAW+1)'($past(pop)))
         else $error("continue write changed confirmation");
      a_upd_conf: assert property (@(posedge clk_sys) disable iff (!nrst)
         ce && h_upd && we |=> conf == cnt)
         else $error("update write did not confirm all entries");
      a_bad_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
         err_ev[ch] |=> bad[ch] && !tx_valid[ch] && evt[ch])
         else $error("error did not lock out the channel");
   end

   // ==================================================================
   // Receive FIFO.
   logic [RAW:0] r_wptr, r_rptr, r_pub, r_pubd, r_tok;
   logic [8:0] r_cnt;
   logic [1:0] r_spd;
   logic [3:0] r_tc;
   logic r_busy, r_spc, r_noack, r_single, split, close, end_ev, take, room, r_ne, pop_rx, tok_we;
   logic [32:0] tok, r_head;

   assign split = trigger_enable && !flush_bad && trig_size > TRIG_MIN && !r_single && !r_spc;
   assign close = r_busy && rx_q_valid && split && r_cnt == trig_size;
   assign room = (r_wptr - r_rptr) <= (RAW+1)'(RX_DEPTH - 2);
   assign rx_ready = ce && room && !close;
   assign take = r_busy && rx_q_valid && rx_ready;
   assign end_ev = ce && r_busy && rx_end;
   assign tok_we = (ce && close) || end_ev;
   assign rx_pub_ev = tok_we;
   assign r_ne = r_rptr != r_pubd;
   assign pop_rx = rd_en && paddr == A_RXREAD && r_ne;

   sbf_rx_token u_tok (
      .snoop_enable(snoop_enable),
      .packet_complete(end_ev),
      .rx_speed(r_spd),
      .block_quadlet_count(r_cnt),
      .tcode(r_tc),
      .snooped_ack(snooped_ack),
      .ack(rx_ack),
      .special(r_spc),
      .no_ack(r_noack),
      .tok(tok)
   );

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         r_wptr <= '0;
         r_rptr <= '0;
         r_pub <= '0;
         r_pubd <= '0;
         r_tok <= '0;
         r_cnt <= '0;
         r_busy <= 1'b0;
         r_spd <= 2'h0;
         r_tc <= 4'h0;
         {r_spc, r_noack, r_single} <= 3'h0;
      end else if (ce) begin
         r_pubd <= r_pub;
         r_rptr <= r_rptr + (RAW+1)'(pop_rx);
         if (!r_busy && rx_start && room) begin
            r_busy <= 1'b1;
            r_tok <= r_wptr;
            r_wptr <= r_wptr + 1'b1;
            r_cnt <= '0;
            r_spd <= rx_speed;
            r_tc <= rx_tcode;
            {r_spc, r_noack, r_single} <= {rx_special, rx_no_ack, rx_single_block};
         end else if (close) begin
            r_pub <= r_wptr;
            r_tok <= r_wptr;
            r_wptr <= r_wptr + 1'b1;
            r_cnt <= '0;
         end else if (end_ev) begin
            r_pub <= r_wptr;
            r_busy <= 1'b0;
         end else if (take) begin
            r_wptr <= r_wptr + 1'b1;
            r_cnt <= r_cnt + 1'b1;
         end
      end
   end

   sbf_ram #(.W(33), .DEPTH(RX_DEPTH)) u_rx_ram (
      .clk_sys(clk_sys),
      .ce(ce),
      .we(tok_we || take),
      .waddr(tok_we ? r_tok[RAW-1:0] : r_wptr[RAW-1:0]),
      .wdata(tok_we ? tok : {1'b0, rx_q_data}),
      .raddr(r_rptr[RAW-1:0]),
      .rdata(r_head)
   );

   // ==================================================================
   // Read data.
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         A_CTRL: next_prdata = {27'h0, flush_bad, trigger_enable, snoop_enable, 2'h0};
         A_TRIG: next_prdata = {23'h0, trig_size};
         A_EVT: next_prdata = {26'h0, bad, 1'b0, evt};
         A_RXSTAT: begin
            next_prdata[RXS_TOK] = r_ne && r_head[CTL_BIT];
            next_prdata[RXS_PC] = r_ne && r_head[CTL_BIT] && r_head[TOK_PC];
            next_prdata[RXS_CNT +: 9] = (r_ne && r_head[CTL_BIT]) ? r_head[TOK_CNT +: 9] : 9'h000;
         end
         A_RXREAD: next_prdata = r_ne ? r_head[31:0] : 32'h0000_0000;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && penable && !pwrite && !rd_wait) begin
         prdata <= next_prdata;
      end
   end

   a_tok_ctl: assert property (@(posedge clk_sys) disable iff (!nrst)
      tok_we |-> tok[CTL_BIT] && tok[6:0] == 7'h00)
      else $error("token entry without control bit");
   a_split_blk: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && close |-> !rx_ready ##1 (r_cnt == 9'h000 && evt[2] && r_pub == r_tok))
      else $error("block close did not publish a block");
   a_rx_pop: assert property (@(posedge clk_sys) disable iff (!nrst)
      pop_rx |=> r_rptr == $past(r_rptr) + 1'b1)
      else $error("receive read did not advance");
   a_snoop_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
      tok_we && !snoop_enable |-> tok[TOK_SACK +: 4] == 4'h0 && !tok[TOK_SNP])
      else $error("snooped ack present without snoop");
endmodule
`default_nettype wire

// [sbf_pkg.sv]
`default_nettype none
package sbf_pkg;
   // ==================================================================
   // Host bus byte addresses.
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_TRIG = 8'h04;
   localparam logic [7:0] A_EVT = 8'h08;
   localparam logic [7:0] A_RXSTAT = 8'h0c;
   localparam logic [7:0] A_RXREAD = 8'hc0;
   // Transmit locations, index 0 asynchronous, index 1 isochronous.
   localparam logic [1:0][7:0] TX_FIRST = {8'h90, 8'h80};
   localparam logic [1:0][7:0] TX_CONT = {8'h94, 8'h84};
   localparam logic [1:0][7:0] TX_UPD = {8'h9c, 8'h8c};
   localparam logic [1:0][7:0] TX_BURST = {8'hb0, 8'ha0};
   // ==================================================================
   // Register fields and reset values.
   localparam int CTRL_ACLR = 0;
   localparam int CTRL_ICLR = 1;
   localparam int CTRL_SNOOP = 2;
   localparam int CTRL_TRIGGER_ENABLE = 3;
   localparam int CTRL_FBAD = 4;
   localparam int EVT_LVL = 4;
   localparam int RXS_TOK = 0;
   localparam int RXS_PC = 1;
   localparam int RXS_CNT = 16;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [8:0] TRIG_RST = 9'h000;
   localparam logic [2:0] EVT_RST = 3'h0;
   localparam logic [8:0] TRIG_MIN = 9'h005;
   // ==================================================================
   // Entry and token layout.
   localparam int CTL_BIT = 32;
   localparam int TOK_SACK = 7;
   localparam int TOK_PC = 11;
   localparam int TOK_SNP = 12;
   localparam int TOK_SPD = 13;
   localparam int TOK_CNT = 15;
   localparam int TOK_TC = 24;
   localparam int TOK_ACK = 28;
   localparam logic [3:0] TC_SPECIAL = 4'he;
   localparam logic [3:0] ACK_NONE = 4'h0;
endpackage
`default_nettype wire

// [sbf_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module sbf_ram
   import sbf_pkg::*;
#(
   parameter int W = 33,
   parameter int DEPTH = 512,
   parameter int AW = $clog2(DEPTH)
) (
   // Clock.
   input wire logic clk_sys,
   input wire logic ce,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Registered read port.
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ce) begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// [sbf_rx_token.sv]
`timescale 1ns/1ps
`default_nettype none
module sbf_rx_token
   import sbf_pkg::*;
(
   // Block description.
   input wire logic snoop_enable,
   input wire logic packet_complete,
   input wire logic [1:0] rx_speed,
   input wire logic [8:0] block_quadlet_count,
   input wire logic [3:0] tcode,
   input wire logic [3:0] snooped_ack,
   input wire logic [3:0] ack,
   input wire logic special,
   input wire logic no_ack,
   // Token entry.
   output logic [32:0] tok
);
   always_comb begin
      tok = '0;
      tok[CTL_BIT] = 1'b1;
      tok[TOK_SACK +: 4] = snoop_enable ? snooped_ack : 4'h0;
      tok[TOK_PC] = packet_complete;
      tok[TOK_SNP] = snoop_enable;
      tok[TOK_SPD +: 2] = rx_speed;
      tok[TOK_CNT +: 9] = block_quadlet_count;
      tok[TOK_TC +: 4] = special ? TC_SPECIAL : tcode;
      tok[TOK_ACK +: 4] = no_ack ? ACK_NONE : ack;
   end
endmodule
`default_nettype wire

// [sbf_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// Transmitter side: drains both transmit FIFOs and logs each entry.
module sbf_link_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Bench controls.
   input wire logic stall,
   input wire logic starve_async,
   input wire logic starve_iso,
   // Asynchronous drain.
   input wire logic async_tx_valid,
   input wire logic [32:0] async_tx_data,
   output logic async_tx_ready,
   output logic async_tx_mid,
   // Isochronous drain.
   input wire logic iso_tx_valid,
   input wire logic [32:0] iso_tx_data,
   output logic iso_tx_ready,
   output logic iso_tx_mid
);
   logic [32:0] q_async[$];
   logic [32:0] q_iso[$];
   assign async_tx_ready = !stall;
   assign iso_tx_ready = !stall;
   // Asking for more while the FIFO is dry stands for a host that falls behind.
   assign async_tx_mid = starve_async;
   assign iso_tx_mid = starve_iso;
   always @(posedge clk_sys) begin
      if (nrst && async_tx_valid && async_tx_ready) begin
         q_async.push_back(async_tx_data);
      end
      if (nrst && iso_tx_valid && iso_tx_ready) begin
         q_iso.push_back(iso_tx_data);
      end
   end
endmodule
`default_nettype wire

// [serial_bus_fifo_host_access_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_bus_fifo_host_access_tb import sbf_pkg::*;;
   typedef struct {logic [1:0] spd; logic [3:0] tc; int n; logic sp; logic na; logic sb; logic snp;
      logic [3:0] sack; logic [3:0] ack;} sbf_rxc_s;
   sbf_rxc_s cs[3] = '{'{2'h2, 4'h7, 14, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9, 4'h1},
      '{2'h0, 4'h0, 8, 1'b1, 1'b1, 1'b0, 1'b1, 4'h5, 4'h3},
      '{2'h1, 4'h1, 7, 1'b0, 1'b0, 1'b1, 1'b0, 4'h6, 4'h2}};
   logic [7:0] ra[5] = '{A_CTRL, A_TRIG, A_EVT, A_RXSTAT, A_RXREAD};
   logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, last_err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic stall = 0, starve_async = 0, starve_iso = 0;
   logic async_tx_valid, async_tx_ready, async_tx_mid, iso_tx_valid, iso_tx_ready, iso_tx_mid;
   logic [32:0] async_tx_data, iso_tx_data;
   logic rx_start = 0, rx_special = 0, rx_no_ack = 0, rx_single_block = 0, rx_q_valid = 0, rx_end = 0;
   logic [1:0] rx_speed = 2'h0;
   logic [3:0] rx_tcode = 4'h0, rx_ack = 4'h0, snooped_ack = 4'h0;
   logic [31:0] rx_q_data = 32'h0;
   logic rx_ready, async_fifo_bad_irq, iso_fifo_bad_irq, rx_data_irq;
   int err_total = 0, cmp_count = 0;
   initial forever #2 clk_sys = ~clk_sys;
   sbf_host_fifo #(.TX_DEPTH(16), .RX_DEPTH(32)) sbf_host_fifo_i (.clk_sys, .ce(1'b1), .nrst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .async_tx_valid, .async_tx_data,
      .async_tx_ready, .async_tx_mid, .iso_tx_valid, .iso_tx_data, .iso_tx_ready, .iso_tx_mid, .rx_start,
      .rx_speed, .rx_tcode, .rx_special, .rx_no_ack, .rx_single_block, .rx_q_valid, .rx_q_data, .rx_ready,
      .rx_end, .rx_ack, .snooped_ack, .async_fifo_bad_irq, .iso_fifo_bad_irq, .rx_data_irq);
   sbf_link_model sbf_link_model_i (.clk_sys, .nrst, .stall, .starve_async, .starve_iso, .async_tx_valid,
      .async_tx_data, .async_tx_ready, .async_tx_mid, .iso_tx_valid, .iso_tx_data, .iso_tx_ready, .iso_tx_mid);
   // ==================================================================
   // Bus and checking tasks.
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD at %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input bit keep);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      q = prdata;
      last_err = pslverr;
      if (n >= 40) chk(1'b0, 1'b1);
      if (!keep) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clk_sys);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input bit keep = 1'b0);
      xfer(1'b0, a, 32'h0, keep);
   endtask
   task automatic burst(input logic [7:0] a, input int n, input logic [31:0] b);
      for (int i = 0; i < n; i++) xfer(1'b1, a, 32'(b + i), i < n - 1);
   endtask
   task automatic expect_tx(input bit iso, input int n, input logic [31:0] b);
      repeat (60) @(posedge clk_sys);
      chk(33'(iso ? sbf_link_model_i.q_iso.size() : sbf_link_model_i.q_async.size()), 33'(n));
      for (int i = 0; i < n; i++) begin
         chk(iso ? sbf_link_model_i.q_iso[i] : sbf_link_model_i.q_async[i], {i == 0, 32'(b + i)});
      end
      sbf_link_model_i.q_iso.delete();
      sbf_link_model_i.q_async.delete();
   endtask
   task automatic rx_run(input int c);
      logic split;
      int rem, bl, idx;
      logic [31:0] t, m;
      split = !(cs[c].sp | cs[c].sb) && cs[c].n > 6;
      wr(A_CTRL, {27'h0, 1'b0, 1'b1, cs[c].snp, 2'h0});
      wr(A_EVT, 32'h7);
      rx_speed <= cs[c].spd;
      rx_tcode <= cs[c].tc;
      rx_special <= cs[c].sp;
      rx_no_ack <= cs[c].na;
      rx_single_block <= cs[c].sb;
      rx_start <= 1'b1;
      @(posedge clk_sys);
      rx_start <= 1'b0;
      for (int i = 0; i < cs[c].n; i++) begin
         rx_q_valid <= 1'b1;
         rx_q_data <= 32'hd000_0000 + 32'(c * 256 + i);
         idx = 0;
         do begin
            @(posedge clk_sys);
            idx++;
         end while (rx_ready !== 1'b1 && idx < 40);
         if (idx >= 40) chk(1'b0, 1'b1);
         if (i == 6) begin
            rx_q_valid <= 1'b0;
            repeat (4) @(posedge clk_sys);
            chk(rx_data_irq, split);
         end
      end
      rx_q_valid <= 1'b0;
      rx_ack <= cs[c].ack;
      snooped_ack <= cs[c].sack;
      rx_end <= 1'b1;
      @(posedge clk_sys);
      rx_end <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk(rx_data_irq, 1'b1);
      rem = cs[c].n;
      idx = 0;
      while (rem > 0) begin
         bl = (split && rem > 6) ? 6 : rem;
         rem -= bl;
         rd(A_RXSTAT);
         chk(q & 32'h01ff_0003, 32'(bl) << 16 | 32'(rem == 0) << 1 | 32'h1);
         t = {cs[c].na ? ACK_NONE : cs[c].ack, cs[c].sp ? TC_SPECIAL : cs[c].tc, 9'(bl), cs[c].spd,
            cs[c].snp, rem == 0, cs[c].snp ? cs[c].sack : 4'h0, 7'h0};
         m = (rem == 0) ? 32'hffff_ffff : 32'h0fff_ffff;
         rd(A_RXREAD);
         chk(q & m, t & m);
         for (int j = 0; j < bl; j++) begin
            rd(A_RXREAD, j < bl - 1);
            chk(q, 32'hd000_0000 + 32'(c * 256 + idx));
            idx++;
         end
      end
      rd(A_RXSTAT);
      chk(q[0], 1'b0);
      $display("test receive case %0d done, mismatches %0d", c, err_total);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==================================================================
   // Test sequence.
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      foreach (ra[i]) begin
         rd(ra[i]);
         chk({last_err, q}, 33'h0);
      end
      rd(8'h40);
      chk(last_err, 1'b1);
      rd(TX_FIRST[0]);
      chk(last_err, 1'b1);
      wr(A_RXREAD, 32'h1);
      chk(last_err, 1'b1);
      wr(A_TRIG, 32'hffff_fe06);
      rd(A_TRIG);
      chk(q, 32'h6);
      $display("test registers done, mismatches %0d", err_total);
      wr(TX_CONT[1], 32'h1);
      repeat (4) @(posedge clk_sys);
      chk(iso_fifo_bad_irq, 1'b1);
      rd(A_EVT);
      chk(q & 32'h33, 32'h22);
      burst(TX_BURST[0], 3, 32'ha000_0000);
      expect_tx(0, 3, 32'ha000_0000);
      wr(TX_FIRST[1], 32'h2);
      wr(TX_UPD[1], 32'h3);
      expect_tx(1, 0, 32'h0);
      wr(A_CTRL, 32'h2);
      wr(A_EVT, 32'h7);
      rd(A_EVT);
      chk(q & 32'h33, 32'h0);
      wr(TX_FIRST[1], 32'hb000_0000);
      chk(last_err, 1'b0);
      burst(TX_CONT[1], 2, 32'hb000_0001);
      expect_tx(1, 0, 32'h0);
      wr(TX_UPD[1], 32'hb000_0003);
      expect_tx(1, 4, 32'hb000_0000);
      burst(TX_BURST[1], 3, 32'hc000_0000);
      expect_tx(1, 3, 32'hc000_0000);
      $display("test iso transmit done, mismatches %0d", err_total);
      wr(TX_FIRST[0], 32'hd000_0000);
      burst(TX_CONT[0], 2, 32'hd000_0001);
      expect_tx(0, 0, 32'h0);
      stall <= 1'b1;
      wr(TX_UPD[0], 32'hd000_0003);
      repeat (10) @(posedge clk_sys);
      stall <= 1'b0;
      expect_tx(0, 4, 32'hd000_0000);
      wr(TX_FIRST[1], 32'he000_0000);
      burst(TX_UPD[1], 2, 32'he000_0001);
      expect_tx(1, 3, 32'he000_0000);
      starve_async <= 1'b1;
      starve_iso <= 1'b1;
      repeat (2) @(posedge clk_sys);
      starve_async <= 1'b0;
      starve_iso <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({async_fifo_bad_irq, iso_fifo_bad_irq}, 2'h3);
      wr(TX_FIRST[0], 32'h4);
      wr(TX_UPD[0], 32'h5);
      expect_tx(0, 0, 32'h0);
      wr(A_CTRL, 32'h3);
      burst(TX_BURST[0], 2, 32'hf000_0000);
      expect_tx(0, 2, 32'hf000_0000);
      $display("test async transmit done, mismatches %0d", err_total);
      for (int c = 0; c < 3; c++) rx_run(c);
      close_out();
   end
   initial begin
      #100000;
      err_total++;
      close_out();
   end
endmodule
`default_nettype wire
